/* File: verilog/cslb_core.sv */
// Core executing stack, loop, divide, branch and bit instructions
`timescale 1ns/1ps
module cslb_core
	import cslb_pkg::*;
(
	input  logic        I_CLK,
	input  logic        I_RESETN,
	input  logic [7:0]  I_MEM_RDATA,
	output logic [15:0] O_MEM_ADDR,
	output logic        O_MEM_RD,
	output logic        O_MEM_WR,
	output logic [7:0]  O_MEM_WDATA,
	output logic [7:0]  O_FLAGS
);
	typedef enum logic [2:0] {
		S_OP, S_ARG, S_ADR, S_IND, S_RD, S_EX, S_WR, S_DIV
	} cslb_state_e;

	cslb_state_e      st_q, st_d;
	logic [7:0]       op_q, op_d;
	logic [3:0][7:0]  arg_q, arg_d;
	logic [2:0]       cnt_q, cnt_d;
	logic [1:0]       pend_q, pend_d;
	logic [15:0]      ea_q, ea_d, dat_q, dat_d;
	logic [7:0]       a_q, a_d, b_q, b_d, flg_q, flg_d;
	logic [15:0]      x_q, x_d, y_q, y_d, sp_q, sp_d, pc_q, pc_d;
	logic [15:0]      addr_q, addr_d;
	logic             rd_q, rd_d, wr_q, wr_d;
	logic [7:0]       wd_q, wd_d;
	logic [15:0]      dacc;
	logic             is_bit, is_idx, take, idle;
	logic [1:0]       pi, rlen, wlen;
	logic [2:0]       need;

	cslb_div_if #(.W(DIV_W)) dv ();
	cslb_idx_if ix ();

	cslb_div #(.W(DIV_W)) u_div (
		.i_clk    (I_CLK),
		.i_resetn (I_RESETN),
		.dv       (dv.unit)
	);

	cslb_idx u_idx (
		.ix (ix.calc)
	);

	function automatic logic [2:0] arg_len(input logic [7:0] op);
		logic [2:0] n;
		n = 3'h0;
		if (op inside {OP_XFER, OP_LEA_X, OP_LEA_Y, OP_LEA_SP,
			OP_LDD_IX, OP_STD_IX})
			n = 3'h1;
		if (op == OP_LDIMM)
			n = 3'h3;
		if (op inside {OP_LOOP, OP_ADDD, OP_SUBD})
			n = 3'h2;
		if (op[7:4] == OP_BRS)
			n = 3'h1;
		if (op[7:4] == OP_BRL)
			n = 3'h2;
		if (op[7:4] == OP_BIT)
			n = (op[3:2] == BM_EXT) ? 3'h3 : 3'h2;
		return n;
	endfunction : arg_len

	function automatic logic [15:0] rd_reg(input logic [2:0] c);
		logic [15:0] v;
		v = 16'h0000;
		case (c)
			R_A: v = {{8{a_q[7]}}, a_q};
			R_B: v = {{8{b_q[7]}}, b_q};
			R_FLG: v = {{8{flg_q[7]}}, flg_q};
			R_D: v = dacc;
			R_X: v = x_q;
			R_Y: v = y_q;
			R_SP: v = sp_q;
			default: v = 16'h0000;
		endcase
		return v;
	endfunction : rd_reg

	function automatic logic [7:0] nzv(input logic [7:0] f,
		input logic [15:0] v, input logic w8);
		logic [7:0] r;
		r = f;
		r[FLG_N] = w8 ? v[7] : v[15];
		r[FLG_Z] = w8 ? (v[7:0] == 8'h00) : (v == 16'h0000);
		r[FLG_V] = 1'b0;
		return r;
	endfunction : nzv

	function automatic logic br_ok(input logic [3:0] c,
		input logic [7:0] f);
		logic n, z, v, cy, r;
		n = f[FLG_N];
		z = f[FLG_Z];
		v = f[FLG_V];
		cy = f[FLG_C];
		unique case (c[3:1])
			3'h0: r = 1'b1;
			3'h1: r = ~(cy | z);
			3'h2: r = ~cy;
			3'h3: r = ~z;
			3'h4: r = ~v;
			3'h5: r = ~n;
			3'h6: r = ~(n ^ v);
			3'h7: r = ~(z | (n ^ v));
		endcase
		return r ^ c[0];
	endfunction : br_ok

	assign dacc = {a_q, b_q};
	assign is_bit = (op_q[7:4] == OP_BIT);
	assign is_idx = (op_q inside {OP_LEA_X, OP_LEA_Y, OP_LEA_SP,
		OP_LDD_IX, OP_STD_IX}) | (is_bit & (op_q[3:2] == BM_IDX));
	assign pi = is_bit ? 2'h1 : 2'h0;
	assign take = (pend_q == 2'h1);
	assign idle = (pend_q == 2'h0);
	assign rlen = (op_q inside {OP_LDD_IX, OP_PULL_DACC}) ? 2'h2 :
		(op_q == OP_PULL_FLG || is_bit) ? 2'h1 : 2'h0;
	assign wlen = (op_q inside {OP_STD_IX, OP_PUSH_DACC}) ? 2'h2 :
		(op_q == OP_PUSH_FLG ||
		(is_bit && op_q[1:0] inside {BK_SET, BK_CLR})) ? 2'h1 : 2'h0;
	// Extra offset bytes count only once the postbyte is in
	assign need = arg_len(op_q) + ((is_idx && cnt_q > {1'b0, pi})
		? {1'b0, ix.extra} : 3'h0);

	assign ix.post = arg_q[pi];
	assign ix.ext = {arg_q[pi + 2'h1], arg_q[pi + 2'h2]};
	assign ix.x = x_q;
	assign ix.y = y_q;
	assign ix.sp = sp_q;
	assign ix.pc = pc_q;
	assign ix.d = dacc;

	assign dv.start = (st_q == S_EX) && (op_q inside {OP_DIVW, OP_DIVL});
	assign dv.num = (op_q == OP_DIVL) ? {y_q, dacc}
		: {{16{a_q[7]}}, dacc};
	assign dv.den = x_q;

	always_comb begin
		logic        w_en;
		logic [2:0]  w_c;
		logic [15:0] w_v;
		logic [16:0] sum;
		logic [15:0] lv;
		logic [7:0]  bv;
		logic        lz;
		w_en = 1'b0;
		w_c = R_A;
		w_v = 16'h0000;
		sum = 17'h00000;
		lv = 16'h0000;
		bv = 8'h00;
		lz = 1'b0;
		st_d = st_q;
		op_d = op_q;
		arg_d = arg_q;
		cnt_d = cnt_q;
		pend_d = (pend_q != 2'h0) ? pend_q - 2'h1 : 2'h0;
		ea_d = ea_q;
		dat_d = dat_q;
		a_d = a_q;
		b_d = b_q;
		flg_d = flg_q;
		x_d = x_q;
		y_d = y_q;
		sp_d = sp_q;
		pc_d = pc_q;
		addr_d = addr_q;
		rd_d = 1'b0;
		wr_d = 1'b0;
		wd_d = wd_q;
		unique case (st_q)
			S_OP: begin
				if (idle) begin
					addr_d = pc_q;
					rd_d = 1'b1;
					pend_d = RD_LAT;
				end else if (take) begin
					op_d = I_MEM_RDATA;
					pc_d = pc_q + 16'h0001;
					cnt_d = 3'h0;
					st_d = S_ARG;
				end
			end
			S_ARG: begin
				if (cnt_q == need) begin
					st_d = S_ADR;
				end else if (idle) begin
					addr_d = pc_q;
					rd_d = 1'b1;
					pend_d = RD_LAT;
				end else if (take) begin
					arg_d[cnt_q[1:0]] = I_MEM_RDATA;
					pc_d = pc_q + 16'h0001;
					cnt_d = cnt_q + 3'h1;
				end
			end
			S_ADR: begin
				cnt_d = 3'h0;
				dat_d = 16'h0000;
				if (is_idx) begin
					ea_d = ix.ea;
					if (ix.bwr) begin
						w_en = 1'b1;
						w_c = ix.bcode;
						w_v = ix.nxt;
					end
				end else if (is_bit) begin
					ea_d = (op_q[3:2] == BM_EXT)
						? {arg_q[1], arg_q[2]} : {8'h00, arg_q[1]};
				end else if (op_q inside {OP_PUSH_DACC, OP_PUSH_FLG}) begin
					ea_d = sp_q - {14'h0, wlen};
					w_en = 1'b1;
					w_c = R_SP;
					w_v = sp_q - {14'h0, wlen};
				end else if (op_q inside {OP_PULL_DACC, OP_PULL_FLG}) begin
					ea_d = sp_q;
					w_en = 1'b1;
					w_c = R_SP;
					w_v = sp_q + {14'h0, rlen};
				end
				st_d = (is_idx && ix.ind) ? S_IND :
					(rlen != 2'h0) ? S_RD : S_EX;
			end
			S_IND: begin
				if (cnt_q == 3'h2) begin
					ea_d = dat_q;
					cnt_d = 3'h0;
					st_d = (rlen != 2'h0) ? S_RD : S_EX;
				end else if (idle) begin
					addr_d = ea_q + {13'h0, cnt_q};
					rd_d = 1'b1;
					pend_d = RD_LAT;
				end else if (take) begin
					dat_d = {dat_q[7:0], I_MEM_RDATA};
					cnt_d = cnt_q + 3'h1;
				end
			end
			S_RD: begin
				if (cnt_q == {1'b0, rlen}) begin
					st_d = S_EX;
				end else if (idle) begin
					addr_d = ea_q + {13'h0, cnt_q};
					rd_d = 1'b1;
					pend_d = RD_LAT;
				end else if (take) begin
					dat_d = {dat_q[7:0], I_MEM_RDATA};
					cnt_d = cnt_q + 3'h1;
				end
			end
			S_EX: begin
				cnt_d = 3'h0;
				st_d = (wlen != 2'h0) ? S_WR : S_OP;
				if (op_q == OP_XFER) begin
					w_en = 1'b1;
					w_c = arg_q[0][2:0];
					w_v = rd_reg(arg_q[0][6:4]);
				end else if (op_q == OP_PUSH_DACC) begin
					dat_d = dacc;
				end else if (op_q == OP_PUSH_FLG) begin
					dat_d = {8'h00, flg_q};
				end else if (op_q == OP_PULL_DACC) begin
					w_en = 1'b1;
					w_c = R_D;
					w_v = dat_q;
				end else if (op_q == OP_PULL_FLG) begin
					flg_d = dat_q[7:0];
				end else if (op_q == OP_LDIMM) begin
					flg_d = nzv(flg_q, {arg_q[1], arg_q[2]},
						~arg_q[0][2]);
					w_en = 1'b1;
					w_c = arg_q[0][2:0];
					w_v = {arg_q[1], arg_q[2]};
				end else if (op_q == OP_LOOP) begin
					lv = rd_reg(arg_q[0][2:0]);
					if (arg_q[0][7:6] == LK_DEC)
						lv = lv - 16'h0001;
					else if (arg_q[0][7:6] == LK_INC)
						lv = lv + 16'h0001;
					lz = arg_q[0][2] ? (lv == 16'h0000)
						: (lv[7:0] == 8'h00);
					w_en = (arg_q[0][7:6] != LK_TST);
					w_c = arg_q[0][2:0];
					w_v = lv;
					if (lz ^ arg_q[0][5])
						pc_d = pc_q + {{7{arg_q[0][4]}}, arg_q[0][4],
							arg_q[1]};
				end else if (op_q inside {OP_DIVW, OP_DIVL}) begin
					st_d = S_DIV;
				end else if (op_q inside {OP_ADDD, OP_SUBD}) begin
					sum = (op_q == OP_ADDD)
						? {1'b0, dacc} + {1'b0, arg_q[0], arg_q[1]}
						: {1'b0, dacc} - {1'b0, arg_q[0], arg_q[1]};
					flg_d = nzv(flg_q, sum[15:0], 1'b0);
					flg_d[FLG_C] = sum[16];
					flg_d[FLG_V] = (dacc[15] ^ sum[15]) &
						(dacc[15] ^ arg_q[0][7] ^ (op_q == OP_ADDD));
					w_en = 1'b1;
					w_c = R_D;
					w_v = sum[15:0];
				end else if (op_q == OP_LDD_IX) begin
					flg_d = nzv(flg_q, dat_q, 1'b0);
					w_en = 1'b1;
					w_c = R_D;
					w_v = dat_q;
				end else if (op_q == OP_STD_IX) begin
					flg_d = nzv(flg_q, dacc, 1'b0);
					dat_d = dacc;
				end else if (op_q inside {OP_LEA_X, OP_LEA_Y, OP_LEA_SP}) begin
					w_en = 1'b1;
					w_c = (op_q == OP_LEA_X) ? R_X :
						(op_q == OP_LEA_Y) ? R_Y : R_SP;
					w_v = ea_q;
				end else if (op_q[7:4] == OP_BRS) begin
					if (br_ok(op_q[3:0], flg_q))
						pc_d = pc_q + {{8{arg_q[0][7]}}, arg_q[0]};
				end else if (op_q[7:4] == OP_BRL) begin
					if (br_ok(op_q[3:0], flg_q))
						pc_d = pc_q + {arg_q[0], arg_q[1]};
				end else if (is_bit) begin
					bv = (op_q[1:0] == BK_SET) ? dat_q[7:0] | arg_q[0] :
						(op_q[1:0] == BK_CLR) ? dat_q[7:0] & ~arg_q[0] :
						dat_q[7:0] & arg_q[0];
					flg_d = nzv(flg_q, {8'h00, bv}, 1'b1);
					dat_d = {8'h00, bv};
				end
			end
			S_WR: begin
				if (cnt_q == {1'b0, wlen}) begin
					st_d = S_OP;
				end else begin
					addr_d = ea_q + {13'h0, cnt_q};
					wr_d = 1'b1;
					wd_d = (cnt_q == 3'h0 && wlen == 2'h2)
						? dat_q[15:8] : dat_q[7:0];
					cnt_d = cnt_q + 3'h1;
				end
			end
			S_DIV: begin
				if (dv.done) begin
					st_d = S_OP;
					flg_d[FLG_C] = dv.dz;
					if (!dv.dz) begin
						flg_d = nzv(flg_q, dv.quo, 1'b0);
						flg_d[FLG_V] = dv.ovf;
						flg_d[FLG_C] = 1'b0;
					end
					if (!dv.dz && !dv.ovf) begin
						w_en = 1'b1;
						w_c = (op_q == OP_DIVL) ? R_Y : R_X;
						w_v = dv.quo;
						a_d = dv.rem[15:8];
						b_d = dv.rem[7:0];
					end
				end
			end
		endcase
		if (w_en) begin
			case (w_c)
				R_A: a_d = w_v[7:0];
				R_B: b_d = w_v[7:0];
				R_FLG: flg_d = w_v[7:0];
				R_D: begin
					a_d = w_v[15:8];
					b_d = w_v[7:0];
				end
				R_X: x_d = w_v;
				R_Y: y_d = w_v;
				R_SP: sp_d = w_v;
				default: ;
			endcase
		end
	end

	always_ff @(posedge I_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			st_q <= S_OP;
			op_q <= 8'h00;
			arg_q <= '0;
			cnt_q <= 3'h0;
			pend_q <= 2'h0;
			ea_q <= 16'h0000;
			dat_q <= 16'h0000;
			a_q <= 8'h00;
			b_q <= 8'h00;
			flg_q <= FLG_RST;
			x_q <= 16'h0000;
			y_q <= 16'h0000;
			sp_q <= SP_RST;
			pc_q <= PC_RST;
			addr_q <= 16'h0000;
			rd_q <= 1'b0;
			wr_q <= 1'b0;
			wd_q <= 8'h00;
		end else begin
			st_q <= st_d;
			op_q <= op_d;
			arg_q <= arg_d;
			cnt_q <= cnt_d;
			pend_q <= pend_d;
			ea_q <= ea_d;
			dat_q <= dat_d;
			a_q <= a_d;
			b_q <= b_d;
			flg_q <= flg_d;
			x_q <= x_d;
			y_q <= y_d;
			sp_q <= sp_d;
			pc_q <= pc_d;
			addr_q <= addr_d;
			rd_q <= rd_d;
			wr_q <= wr_d;
			wd_q <= wd_d;
		end
	end

	assign O_MEM_ADDR = addr_q;
	assign O_MEM_RD = rd_q;
	assign O_MEM_WR = wr_q;
	assign O_MEM_WDATA = wd_q;
	assign O_FLAGS = flg_q;
endmodule : cslb_core

/* File: verilog/cslb_pkg.sv */
// Constants shared by the stack, loop and branch core
// Function
// - Byte into word register sign extends
// - Push and pull double accumulator, high first
// - Push and pull the condition flags
// - Stack pointer effective address adds signed offset
// - Pre/post increment/decrement by -8..+8, X/Y/SP
// - Auto adjust costs no extra bytes or cycles
// - Loop decrement/increment/test then branch on zero or nonzero
// - Loop displacement is nine-bit signed
// - Signed word divide gives signed word quotient
// - Signed long divide, numerator upper half Y
// - Arithmetic and loads update condition flags
// - Short branch uses signed byte displacement
// - Long branch uses sixteen-bit displacement
// - Transfer copies stack pointer and index both ways
// - Indirect indexed with constant or D, PC base
// - Effective address loads into X, Y or SP
// - Bit set/clear/test: direct, extended, indexed
package cslb_pkg;
	localparam logic [15:0] PC_RST       = 16'h0000;
	localparam logic [15:0] SP_RST       = 16'h0000;
	localparam logic [7:0]  FLG_RST      = 8'hd0;
	localparam logic [1:0]  RD_LAT       = 2'h2;
	localparam int          DIV_W        = 16;
	localparam int          FLG_N        = 3;
	localparam int          FLG_Z        = 2;
	localparam int          FLG_V        = 1;
	localparam int          FLG_C        = 0;
	localparam logic [2:0]  R_A          = 3'h0;
	localparam logic [2:0]  R_B          = 3'h1;
	localparam logic [2:0]  R_FLG        = 3'h2;
	localparam logic [2:0]  R_D          = 3'h4;
	localparam logic [2:0]  R_X          = 3'h5;
	localparam logic [2:0]  R_Y          = 3'h6;
	localparam logic [2:0]  R_SP         = 3'h7;
	localparam logic [7:0]  OP_XFER      = 8'h01;
	localparam logic [7:0]  OP_PUSH_DACC = 8'h02;
	localparam logic [7:0]  OP_PULL_DACC = 8'h03;
	localparam logic [7:0]  OP_PUSH_FLG  = 8'h04;
	localparam logic [7:0]  OP_PULL_FLG  = 8'h05;
	localparam logic [7:0]  OP_LDIMM     = 8'h08;
	localparam logic [7:0]  OP_LOOP      = 8'h0f;
	localparam logic [7:0]  OP_DIVW      = 8'h10;
	localparam logic [7:0]  OP_DIVL      = 8'h11;
	localparam logic [7:0]  OP_LEA_X     = 8'h1a;
	localparam logic [7:0]  OP_LEA_Y     = 8'h1b;
	localparam logic [7:0]  OP_LEA_SP    = 8'h1c;
	localparam logic [7:0]  OP_LDD_IX    = 8'h20;
	localparam logic [7:0]  OP_STD_IX    = 8'h21;
	localparam logic [7:0]  OP_ADDD      = 8'h24;
	localparam logic [7:0]  OP_SUBD      = 8'h25;
	localparam logic [3:0]  OP_BRS       = 4'h3;
	localparam logic [3:0]  OP_BRL       = 4'h4;
	localparam logic [3:0]  OP_BIT       = 4'h6;
	localparam logic [1:0]  BM_DIR       = 2'h0;
	localparam logic [1:0]  BM_EXT       = 2'h1;
	localparam logic [1:0]  BM_IDX       = 2'h2;
	localparam logic [1:0]  BK_SET       = 2'h0;
	localparam logic [1:0]  BK_CLR       = 2'h1;
	localparam logic [1:0]  LK_DEC       = 2'h0;
	localparam logic [1:0]  LK_INC       = 2'h1;
	localparam logic [1:0]  LK_TST       = 2'h2;
	localparam logic [1:0]  FORM_Z       = 2'h0;
	localparam logic [1:0]  FORM_8       = 2'h1;
	localparam logic [1:0]  FORM_16      = 2'h2;
	localparam logic [1:0]  FORM_D       = 2'h3;
endpackage : cslb_pkg

/* File: verilog/cslb_if.sv */
// Interfaces between the core, its divider and its address unit
`timescale 1ns/1ps
interface cslb_div_if #(parameter int W = 16);
	logic           start;
	logic [2*W-1:0] num;
	logic [W-1:0]   den;
	logic           done;
	logic [W-1:0]   quo;
	logic [W-1:0]   rem;
	logic           ovf;
	logic           dz;
	modport core (output start, num, den, input done, quo, rem, ovf, dz);
	modport unit (input start, num, den, output done, quo, rem, ovf, dz);
endinterface : cslb_div_if

interface cslb_idx_if;
	logic [7:0]  post;
	logic [15:0] ext;
	logic [15:0] x;
	logic [15:0] y;
	logic [15:0] sp;
	logic [15:0] pc;
	logic [15:0] d;
	logic [15:0] ea;
	logic [15:0] nxt;
	logic [2:0]  bcode;
	logic        bwr;
	logic        ind;
	logic [1:0]  extra;
	modport core (output post, ext, x, y, sp, pc, d,
		input ea, nxt, bcode, bwr, ind, extra);
	modport calc (input post, ext, x, y, sp, pc, d,
		output ea, nxt, bcode, bwr, ind, extra);
endinterface : cslb_idx_if

/* File: verilog/cslb_div.sv */
// Iterative signed divider, 2W by W bits
`timescale 1ns/1ps
module cslb_div
	import cslb_pkg::*;
#(
	parameter int W = DIV_W
)
(
	input  logic          i_clk,
	input  logic          i_resetn,
	cslb_div_if.unit      dv
);
	localparam int CW = $clog2(2 * W + 1);

	if (W < 2) begin : g_chk
		$error("Divider width too small");
	end

	logic           busy_q, busy_d, done_q, done_d;
	logic           nq_q, nq_d, nr_q, nr_d, dz_q, dz_d;
	logic [CW-1:0]  cnt_q, cnt_d;
	logic [W:0]     r_q, r_d, t;
	logic [2*W-1:0] q_q, q_d;
	logic [W-1:0]   dm_q, dm_d;

	always_comb begin
		busy_d = busy_q;
		cnt_d = cnt_q;
		r_d = r_q;
		q_d = q_q;
		dm_d = dm_q;
		nq_d = nq_q;
		nr_d = nr_q;
		dz_d = dz_q;
		done_d = 1'b0;
		t = {r_q[W-1:0], q_q[2*W-1]};
		if (dv.start) begin
			busy_d = 1'b1;
			cnt_d = CW'(2 * W);
			q_d = dv.num[2*W-1] ? -dv.num : dv.num;
			dm_d = dv.den[W-1] ? -dv.den : dv.den;
			r_d = '0;
			nq_d = dv.num[2*W-1] ^ dv.den[W-1];
			nr_d = dv.num[2*W-1];
			dz_d = (dv.den == '0);
		end else if (busy_q) begin
			// Restoring step, one quotient bit per cycle
			if (t >= {1'b0, dm_q}) begin
				r_d = t - {1'b0, dm_q};
				q_d = {q_q[2*W-2:0], 1'b1};
			end else begin
				r_d = t;
				q_d = {q_q[2*W-2:0], 1'b0};
			end
			cnt_d = cnt_q - 1'b1;
			if (cnt_q == CW'(1)) begin
				busy_d = 1'b0;
				done_d = 1'b1;
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			busy_q <= 1'b0;
			done_q <= 1'b0;
			nq_q <= 1'b0;
			nr_q <= 1'b0;
			dz_q <= 1'b0;
			cnt_q <= '0;
			r_q <= '0;
			q_q <= '0;
			dm_q <= '0;
		end else begin
			busy_q <= busy_d;
			done_q <= done_d;
			nq_q <= nq_d;
			nr_q <= nr_d;
			dz_q <= dz_d;
			cnt_q <= cnt_d;
			r_q <= r_d;
			q_q <= q_d;
			dm_q <= dm_d;
		end
	end

	assign dv.done = done_q;
	assign dv.quo = nq_q ? -q_q[W-1:0] : q_q[W-1:0];
	assign dv.rem = nr_q ? -r_q[W-1:0] : r_q[W-1:0];
	assign dv.dz = dz_q;
	assign dv.ovf = (|q_q[2*W-1:W]) |
		(q_q[W-1] & ~(nq_q & ~(|q_q[W-2:0])));
endmodule : cslb_div

/* File: verilog/cslb_idx.sv */
// Indexed address calculation from the postbyte
`timescale 1ns/1ps
module cslb_idx
	import cslb_pkg::*;
(
	cslb_idx_if.calc ix
);
	logic [15:0] base, adj;

	always_comb begin
		unique case (ix.post[6:5])
			2'h0: base = ix.x;
			2'h1: base = ix.y;
			2'h2: base = ix.sp;
			2'h3: base = ix.pc;
		endcase
		unique case (ix.post[6:5])
			2'h0: ix.bcode = R_X;
			2'h1: ix.bcode = R_Y;
			2'h2: ix.bcode = R_SP;
			2'h3: ix.bcode = R_D;
		endcase
		adj = ix.post[3] ? {12'hfff, ix.post[3:0]}
			: {12'h000, ix.post[3:0]} + 16'h0001;
		ix.ea = base;
		ix.nxt = base;
		ix.bwr = 1'b0;
		ix.ind = 1'b0;
		ix.extra = 2'h0;
		if (!ix.post[7]) begin
			ix.nxt = base + adj;
			ix.ea = ix.post[4] ? base : base + adj;
			ix.bwr = (ix.post[6:5] != 2'h3);
		end else begin
			ix.ind = ix.post[4];
			unique case (ix.post[3:2])
				FORM_Z: ix.ea = base;
				FORM_8: begin
					ix.extra = 2'h1;
					ix.ea = base + {{8{ix.ext[15]}}, ix.ext[15:8]};
				end
				FORM_16: begin
					ix.extra = 2'h2;
					ix.ea = base + ix.ext;
				end
				FORM_D: ix.ea = base + ix.d;
			endcase
		end
	end
endmodule : cslb_idx

/* File: tb/cslb_checker.sv */
// Bus protocol checks for the stack, loop and branch core
`timescale 1ns/1ps
module cslb_checker (
	input logic        I_CLK,
	input logic        I_RESETN,
	input logic [7:0]  I_MEM_RDATA,
	input logic [15:0] O_MEM_ADDR,
	input logic        O_MEM_RD,
	input logic        O_MEM_WR,
	input logic [7:0]  O_MEM_WDATA,
	input logic [7:0]  O_FLAGS
);
	logic [6:0] idle_q;
	logic [6:0] idle_d;

	// Cycles since the last read request
	always_comb begin
		idle_d = O_MEM_RD ? 7'h00 : idle_q + 7'h01;
	end
	always_ff @(posedge I_CLK or negedge I_RESETN) begin
		if (!I_RESETN)
			idle_q <= 7'h00;
		else
			idle_q <= idle_d;
	end

	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (!I_RESETN);

	sequence s_wr_pair;
		O_MEM_WR ##1 O_MEM_WR;
	endsequence
	sequence s_rd_gap;
		!O_MEM_RD ##1 !O_MEM_RD;
	endsequence

	property p_rd_space;
		O_MEM_RD |=> s_rd_gap;
	endproperty
	property p_rd_wr_excl;
		!(O_MEM_RD && O_MEM_WR);
	endproperty
	property p_pair_order;
		s_wr_pair |-> O_MEM_ADDR == $past(O_MEM_ADDR) + 16'h0001;
	endproperty
	property p_pair_len;
		s_wr_pair |=> !O_MEM_WR;
	endproperty
	property p_wdata_hold;
		!O_MEM_WR |-> $stable(O_MEM_WDATA);
	endproperty
	property p_addr_hold;
		!O_MEM_RD && !O_MEM_WR |-> $stable(O_MEM_ADDR);
	endproperty
	property p_first_fetch;
		$rose(I_RESETN) |-> ##[1:2] (O_MEM_RD && O_MEM_ADDR == 16'h0000);
	endproperty
	property p_fetch_live;
		idle_q < 7'h40;
	endproperty

	a_rd_space: assert property (p_rd_space)
		else $error("read requests too close");
	a_rd_wr_excl: assert property (p_rd_wr_excl)
		else $error("read and write together");
	a_pair_order: assert property (p_pair_order)
		else $error("word bytes not at ascending addresses");
	a_pair_len: assert property (p_pair_len)
		else $error("write burst longer than a word");
	a_wdata_hold: assert property (p_wdata_hold)
		else $error("write data moved while idle");
	a_addr_hold: assert property (p_addr_hold)
		else $error("address moved while idle");
	a_first_fetch: assert property (p_first_fetch)
		else $error("no fetch from zero after reset");
	a_fetch_live: assert property (p_fetch_live)
		else $error("no fetch for too long");
endmodule : cslb_checker

bind cslb_core cslb_checker u_cslb_checker (
	.I_CLK      (I_CLK),
	.I_RESETN   (I_RESETN),
	.I_MEM_RDATA(I_MEM_RDATA),
	.O_MEM_ADDR (O_MEM_ADDR),
	.O_MEM_RD   (O_MEM_RD),
	.O_MEM_WR   (O_MEM_WR),
	.O_MEM_WDATA(O_MEM_WDATA),
	.O_FLAGS    (O_FLAGS)
);

/* File: tb/cslb_mem_model.sv */
// Byte-wide program and stack memory answering one cycle after a read
`timescale 1ns/1ps
module cslb_mem_model (
	input  logic        i_clk,
	input  logic [15:0] i_addr,
	input  logic        i_rd,
	input  logic        i_wr,
	input  logic [7:0]  i_wdata,
	output logic [7:0]  o_rdata
);
	logic [7:0] mem [0:65535];

	initial o_rdata = 8'h00;
	// Data valid only in the cycle after the request, scrambled otherwise
	always @(posedge i_clk) begin
		if (i_wr)
			mem[i_addr] <= i_wdata;
		if (i_rd)
			o_rdata <= mem[i_addr];
		else
			o_rdata <= ~o_rdata;
	end
endmodule : cslb_mem_model

/* File: tb/tb_top.sv */
// Self-checking testbench for the stack, loop and branch core
`timescale 1ns/1ps
module tb_top;
	logic        clk;
	logic        resetn;
	logic [7:0]  rdata;
	logic [15:0] addr;
	logic        rd;
	logic        wr;
	logic [7:0]  wdata;
	logic [7:0]  flags;
	int          miscompares;
	int          comparisons;
	int          cyc;

	cslb_core u_cslb_core (
		.I_CLK      (clk),
		.I_RESETN   (resetn),
		.I_MEM_RDATA(rdata),
		.O_MEM_ADDR (addr),
		.O_MEM_RD   (rd),
		.O_MEM_WR   (wr),
		.O_MEM_WDATA(wdata),
		.O_FLAGS    (flags)
	);
	cslb_mem_model u_mem (
		.i_clk  (clk),
		.i_addr (addr),
		.i_rd   (rd),
		.i_wr   (wr),
		.i_wdata(wdata),
		.o_rdata(rdata)
	);

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task close_out;
		$display("miscompares=%0d comparisons=%0d", miscompares, comparisons);
		if (miscompares == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : close_out

	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			close_out;
		end
	end

	task chk(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	// Reset, clear memory and load a program; reset stays low
	task boot(input int n, input logic [511:0] v);
		resetn = 1'b0;
		for (int i = 0; i < 65536; i++)
			u_mem.mem[i] = 8'h00;
		for (int i = 0; i < n; i++)
			u_mem.mem[i] = v[8*(n-1-i) +: 8];
		repeat (3) @(negedge clk);
	endtask : boot

	task pk(input logic [15:0] a, input logic [15:0] w);
		u_mem.mem[a] = w[15:8];
		u_mem.mem[a + 16'h0001] = w[7:0];
	endtask : pk

	// Wait for a write to one address and judge its data
	task ew(input logic [15:0] a, input logic [7:0] d);
		int n;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (!(wr === 1'b1 && addr === a) && n < 3000);
		chk(addr, a);
		chk({8'h00, wdata}, {8'h00, d});
	endtask : ew

	task ew16(input logic [15:0] a, input logic [15:0] w);
		ew(a, w[15:8]);
		ew(a + 16'h0001, w[7:0]);
	endtask : ew16

	// Upper flag bits keep their reset value d in every scenario
	task cf(input logic [3:0] e);
		chk({8'h00, flags}, {8'h00, 4'hd, e});
	endtask : cf

	task t_stack;
		boot(34, {144'h0804abcd_1cc4f6_02_1ac405_0154_02_08052000,
			128'h0157_0176_0164_02_08000085_0105_0154_02});
		resetn = 1'b1;
		ew16(16'hfff4, 16'habcd);
		ew16(16'hfff2, 16'hfff9);
		ew16(16'h1ffe, 16'h2000);
		ew16(16'h1ffc, 16'hff85);
	endtask : t_stack

	task t_auto;
		boot(18, 144'h08053000_08045aa5_2117_210f_0154_02_2148_02);
		resetn = 1'b1;
		ew16(16'h3000, 16'h5aa5);
		ew16(16'h3007, 16'h5aa5);
		ew16(16'hfffe, 16'h3007);
		ew16(16'hfff6, 16'h3007);
		ew16(16'hfff4, 16'h3007);
	endtask : t_auto

	task t_loop;
		boot(29, {120'h080100fd_08000011_0f71fd_08050002,
			112'h0f35fd_02_0154_0f8504_0804eeee_02});
		resetn = 1'b1;
		ew16(16'hfffe, 16'h1100);
		ew16(16'hfffc, 16'h0000);
	endtask : t_loop

	task t_div;
		boot(35, {136'h0804fff9_08050002_10_02_0154_02_0806ffff,
			144'h0804fff0_08050004_11_0164_02_08050000_10_02});
		resetn = 1'b1;
		ew16(16'hfffe, 16'hffff);
		cf(4'h8);
		ew16(16'hfffc, 16'hfffd);
		ew16(16'hfffa, 16'hfffc);
		cf(4'h8);
		ew16(16'hfff8, 16'hfffc);
		cf(4'h5);
	endtask : t_div

	task t_branch;
		boot(24, 192'h08040001_3604_080000ee_400004_080000dd_3704_08010077_02);
		resetn = 1'b1;
		ew16(16'hfffe, 16'h0077);
		cf(4'h0);
	endtask : t_branch

	// Push/pull D and flags, add/subtract flags, index Y from D
	task t_flags;
		boot(27, {104'h08041234_02_08040000_03_248000,
			112'h251235_04_08050000_05_1b8c_0164_02});
		resetn = 1'b1;
		ew16(16'hfffe, 16'h1234);
		ew(16'hffff, 8'hd2);
		ew16(16'hfffe, 16'h7fff);
		cf(4'h2);
	endtask : t_flags

	task t_ind;
		boot(12, 96'h08040100_20fc_02_20f80115_02);
		pk(16'h0106, 16'h0210);
		pk(16'h0210, 16'hcafe);
		pk(16'h0120, 16'h0220);
		pk(16'h0220, 16'hbeef);
		resetn = 1'b1;
		ew16(16'hfffe, 16'hcafe);
		ew16(16'hfffc, 16'hbeef);
	endtask : t_ind

	task t_bit;
		boot(15, 120'h60f040_650f0040_08050040_6a0f80_02);
		pk(16'h0040, 16'h0f00);
		resetn = 1'b1;
		ew(16'h0040, 8'hff);
		ew(16'h0040, 8'hf0);
		ew16(16'hfffe, 16'h0000);
		cf(4'h4);
	endtask : t_bit

	initial begin
		resetn = 1'b0;
		miscompares = 0;
		comparisons = 0;
		cyc = 0;
		@(negedge clk);
		t_stack;
		t_auto;
		t_loop;
		t_div;
		t_branch;
		t_ind;
		t_bit;
		t_flags;
		close_out;
	end
endmodule : tb_top
